/* File: hw/fcs_pkg.sv */
// Shared constants and types for the flash command and status controller
package fcs_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_ACC_NS = 80;
    localparam int T_WP_NS = 50;
    localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------------
    // Device command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_IDENTIFY = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int SR_READY = 7;
    localparam int SR_SUSPENDED = 6;
    localparam int SR_ERASE_FAIL = 5;
    localparam int SR_PROG_FAIL = 4;
    localparam int SR_SUPPLY_MISSING = 3;
    localparam logic [7:0] SR_RESET = 8'h00;
    localparam logic [7:0] SR_ERR_MASK = 8'h38;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_IDENT = 4'h1,
        OP_STATUS = 4'h2,
        OP_CLEAR = 4'h3,
        OP_PROGRAM = 4'h4,
        OP_ERASE = 4'h5,
        OP_SUSPEND = 4'h6,
        OP_RESUME = 4'h7
    } fcs_op_t;

    typedef enum logic [1:0] {
        MD_ARRAY = 2'b00,
        MD_IDENT = 2'b01,
        MD_STATUS = 2'b10,
        MD_OTHER = 2'b11
    } fcs_mode_t;

    typedef struct packed {
        fcs_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic boot_unlock;
    } fcs_req_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_o;
        logic dq_oe;
    } fcs_pins_t;

endpackage : fcs_pkg

/* File: hw/fcs_bus_cycle.sv */
// One read or write cycle on the flash parallel bus
`timescale 1ns/1ns
module fcs_bus_cycle
    import fcs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic wr_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic [DATA_W-1:0] dq_i,
    output fcs_pins_t pins_o,
    output logic [DATA_W-1:0] rdata_o,
    output logic done_o
);

    typedef enum logic [1:0] {
        BC_IDLE = 2'b00,
        BC_SETUP = 2'b01,
        BC_STROBE = 2'b10,
        BC_HOLD = 2'b11
    } fcs_bc_state_t;

    fcs_bc_state_t state_ff;
    logic wr_ff;
    logic [2:0] cnt_ff;

    // ------------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= BC_IDLE;
            wr_ff <= 1'b0;
            cnt_ff <= 3'h0;
            pins_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                        addr: '0, dq_o: '0, dq_oe: 1'b0};
            rdata_o <= '0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            unique case (state_ff)
                BC_IDLE: begin
                    if (start_i) begin
                        // Address and data held for the whole cycle
                        pins_o.ce_n <= 1'b0;
                        pins_o.addr <= addr_i;
                        pins_o.dq_o <= wdata_i;
                        pins_o.dq_oe <= wr_i;
                        wr_ff <= wr_i;
                        state_ff <= BC_SETUP;
                    end
                end
                BC_SETUP: begin
                    pins_o.we_n <= ~wr_ff;
                    pins_o.oe_n <= wr_ff;
                    cnt_ff <= wr_ff ? 3'(WP_CYC - 1) : 3'(ACC_CYC - 1);
                    state_ff <= BC_STROBE;
                end
                BC_STROBE: begin
                    if (cnt_ff == 3'h0) begin
                        if (!wr_ff) begin
                            rdata_o <= dq_i;
                        end
                        // Strobe released each cycle so status updates
                        pins_o.we_n <= 1'b1;
                        pins_o.oe_n <= 1'b1;
                        state_ff <= BC_HOLD;
                    end else begin
                        cnt_ff <= cnt_ff - 3'h1;
                    end
                end
                BC_HOLD: begin
                    pins_o.ce_n <= 1'b1;
                    pins_o.dq_oe <= 1'b0;
                    done_o <= 1'b1;
                    state_ff <= BC_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_addr_stable;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!pins_o.ce_n && $past(!pins_o.ce_n)) |-> $stable(pins_o.addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("address moved while chip select low");

    property p_read_oe_toggle;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == BC_IDLE && start_i && !wr_i) |->
            ##1 pins_o.oe_n ##1 !pins_o.oe_n [*2] ##1 pins_o.oe_n
            ##1 done_o;
    endproperty
    a_read_oe_toggle: assert property (p_read_oe_toggle)
        else $error("read cycle output enable shape wrong");

endmodule : fcs_bus_cycle

/* File: hw/fcs_ctrl.sv */
// Host controller that drives the boot-block flash command sequences
`timescale 1ns/1ns
module fcs_ctrl
    import fcs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic req_valid_i,
    input fcs_req_t req_i,
    input wire logic [DATA_W-1:0] dq_i,
    output logic req_ready_o,
    output logic done_o,
    output logic [DATA_W-1:0] rdata_o,
    output logic [7:0] status_o,
    output logic error_o,
    output fcs_pins_t pins_o,
    output logic rp_n_o,
    output logic byte_n_o,
    output logic vpp_en_o,
    output logic wp_o
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PRE = 3'b001,
        ST_SECOND = 3'b010,
        ST_READ = 3'b011,
        ST_POLL = 3'b100,
        ST_FIN = 3'b101
    } fcs_state_t;

    fcs_state_t state_ff;
    fcs_mode_t mode_ff;
    fcs_req_t req_ff;
    logic [7:0] pre_cmd_ff;
    logic [7:0] last_cmd_ff;
    logic skip_pre_ff;
    logic pend_ff;
    logic bus_start_ff;
    logic bus_wr_ff;
    logic [DATA_W-1:0] bus_wdata_ff;
    logic [DATA_W-1:0] bus_rdata;
    logic bus_done;

    // First command of each operation
    function automatic logic [7:0] first_cmd(input fcs_op_t op);
        unique case (op)
            OP_READ: first_cmd = CMD_READ_ARRAY;
            OP_IDENT: first_cmd = CMD_IDENTIFY;
            OP_STATUS: first_cmd = CMD_READ_STATUS;
            OP_CLEAR: first_cmd = CMD_CLEAR_STATUS;
            OP_PROGRAM: first_cmd = CMD_PROG_SETUP;
            OP_ERASE: first_cmd = CMD_ERASE_SETUP;
            OP_SUSPEND: first_cmd = CMD_SUSPEND;
            OP_RESUME: first_cmd = CMD_CONFIRM;
            default: first_cmd = CMD_READ_ARRAY;
        endcase
    endfunction : first_cmd

    // Mode command already in force, so the write may be skipped
    function automatic logic mode_holds(input fcs_op_t op,
                                        input fcs_mode_t md);
        mode_holds = (op == OP_READ && md == MD_ARRAY) ||
                     (op == OP_IDENT && md == MD_IDENT) ||
                     (op == OP_STATUS && md == MD_STATUS);
    endfunction : mode_holds

    // ------------------------------------------------------------------
    // Bus cycle engine
    // ------------------------------------------------------------------
    fcs_bus_cycle u_bus (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(bus_start_ff),
        .wr_i(bus_wr_ff),
        .addr_i(req_ff.addr),
        .wdata_i(bus_wdata_ff),
        .dq_i(dq_i),
        .pins_o(pins_o),
        .rdata_o(bus_rdata),
        .done_o(bus_done)
    );

    // ------------------------------------------------------------------
    // Sequence state machine
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_IDLE;
            mode_ff <= MD_ARRAY;
            req_ff <= '0;
            pre_cmd_ff <= CMD_READ_ARRAY;
            last_cmd_ff <= CMD_READ_ARRAY;
            skip_pre_ff <= 1'b0;
            pend_ff <= 1'b0;
            bus_start_ff <= 1'b0;
            bus_wr_ff <= 1'b0;
            bus_wdata_ff <= '0;
            req_ready_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= '0;
            status_o <= SR_RESET;
        end else begin
            bus_start_ff <= 1'b0;
            done_o <= 1'b0;
            unique case (state_ff)
                ST_IDLE: begin
                    req_ready_o <= 1'b1;
                    if (req_valid_i && req_ready_o) begin
                        req_ready_o <= 1'b0;
                        req_ff <= req_i;
                        pre_cmd_ff <= first_cmd(req_i.op);
                        skip_pre_ff <= mode_holds(req_i.op, mode_ff);
                        state_ff <= ST_PRE;
                    end
                end
                ST_PRE: begin
                    if (skip_pre_ff) begin
                        state_ff <= ST_READ;
                    end else if (!pend_ff) begin
                        bus_start_ff <= 1'b1;
                        bus_wr_ff <= 1'b1;
                        bus_wdata_ff <= {8'h00, pre_cmd_ff};
                        last_cmd_ff <= pre_cmd_ff;
                        pend_ff <= 1'b1;
                    end else if (bus_done) begin
                        pend_ff <= 1'b0;
                        unique case (req_ff.op)
                            OP_READ: mode_ff <= MD_ARRAY;
                            OP_IDENT: mode_ff <= MD_IDENT;
                            OP_STATUS: mode_ff <= MD_STATUS;
                            default: mode_ff <= MD_OTHER;
                        endcase
                        unique case (req_ff.op)
                            OP_READ, OP_IDENT, OP_STATUS:
                                state_ff <= ST_READ;
                            OP_PROGRAM, OP_ERASE:
                                state_ff <= ST_SECOND;
                            OP_SUSPEND, OP_RESUME:
                                state_ff <= ST_POLL;
                            default: state_ff <= ST_FIN;
                        endcase
                    end
                end
                ST_SECOND: begin
                    if (!pend_ff) begin
                        bus_start_ff <= 1'b1;
                        bus_wr_ff <= 1'b1;
                        // Program value, or confirm at the block address
                        bus_wdata_ff <= (req_ff.op == OP_PROGRAM) ?
                            req_ff.data : {8'h00, CMD_CONFIRM};
                        pend_ff <= 1'b1;
                    end else if (bus_done) begin
                        pend_ff <= 1'b0;
                        mode_ff <= MD_STATUS;
                        state_ff <= ST_POLL;
                    end
                end
                ST_READ: begin
                    if (!pend_ff) begin
                        bus_start_ff <= 1'b1;
                        bus_wr_ff <= 1'b0;
                        pend_ff <= 1'b1;
                    end else if (bus_done) begin
                        pend_ff <= 1'b0;
                        rdata_o <= bus_rdata;
                        if (req_ff.op == OP_STATUS) begin
                            status_o <= bus_rdata[7:0];
                        end
                        state_ff <= ST_FIN;
                    end
                end
                ST_POLL: begin
                    if (!pend_ff) begin
                        bus_start_ff <= 1'b1;
                        bus_wr_ff <= 1'b0;
                        pend_ff <= 1'b1;
                    end else if (bus_done) begin
                        pend_ff <= 1'b0;
                        status_o <= bus_rdata[7:0];
                        rdata_o <= bus_rdata;
                        mode_ff <= MD_STATUS;
                        // Poll again until the ready flag reads one
                        if (bus_rdata[SR_READY]) begin
                            state_ff <= ST_FIN;
                        end
                    end
                end
                ST_FIN: begin
                    done_o <= 1'b1;
                    state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Device side control pins
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rp_n_o <= 1'b0;
            byte_n_o <= 1'b1;
            vpp_en_o <= 1'b0;
            wp_o <= 1'b0;
        end else begin
            rp_n_o <= 1'b1;
            byte_n_o <= 1'b1;
            if (state_ff == ST_IDLE && req_valid_i && req_ready_o &&
                (req_i.op == OP_PROGRAM || req_i.op == OP_ERASE)) begin
                vpp_en_o <= 1'b1;
                wp_o <= req_i.boot_unlock;
            end else if (state_ff == ST_POLL && bus_done &&
                         bus_rdata[SR_READY] &&
                         !bus_rdata[SR_SUSPENDED]) begin
                // Supply dropped only once the operation has finished
                vpp_en_o <= 1'b0;
                wp_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Error summary
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            error_o <= 1'b0;
        end else if (state_ff == ST_POLL && bus_done) begin
            error_o <= |(bus_rdata[7:0] & SR_ERR_MASK);
        end else if (state_ff == ST_FIN && req_ff.op == OP_CLEAR) begin
            error_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_prog_after_setup;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (bus_start_ff && state_ff == ST_SECOND && req_ff.op == OP_PROGRAM)
            |-> last_cmd_ff == CMD_PROG_SETUP && bus_wdata_ff == req_ff.data;
    endproperty
    a_prog_after_setup: assert property (p_prog_after_setup)
        else $error("program data not preceded by setup");

    property p_erase_confirm;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (bus_start_ff && state_ff == ST_SECOND && req_ff.op == OP_ERASE)
            |-> last_cmd_ff == CMD_ERASE_SETUP &&
                bus_wdata_ff[7:0] == CMD_CONFIRM
            ##[1:8] (!pins_o.we_n && pins_o.addr == req_ff.addr);
    endproperty
    a_erase_confirm: assert property (p_erase_confirm)
        else $error("erase confirm missing or wrong address");

    property p_vpp_during_poll;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == ST_POLL &&
         (req_ff.op == OP_PROGRAM || req_ff.op == OP_ERASE))
            |-> vpp_en_o;
    endproperty
    a_vpp_during_poll: assert property (p_vpp_during_poll)
        else $error("supply dropped before ready");

    property p_poll_repeats;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == ST_POLL && bus_done && !bus_rdata[SR_READY])
            |=> state_ff == ST_POLL ##1 bus_start_ff;
    endproperty
    a_poll_repeats: assert property (p_poll_repeats)
        else $error("stopped polling while busy");

    property p_boot_unlock;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        $rose(vpp_en_o) |-> wp_o == req_ff.boot_unlock;
    endproperty
    a_boot_unlock: assert property (p_boot_unlock)
        else $error("boot unlock not raised with supply");

    property p_array_return;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == ST_IDLE && req_valid_i && req_ready_o &&
         req_i.op == OP_READ && mode_ff != MD_ARRAY)
            |=> pre_cmd_ff == CMD_READ_ARRAY && !skip_pre_ff
            ##1 bus_start_ff && bus_wdata_ff[7:0] == CMD_READ_ARRAY;
    endproperty
    a_array_return: assert property (p_array_return)
        else $error("read array command not issued");

    property p_status_reread;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_ff == ST_POLL && bus_start_ff) |->
            ##1 pins_o.oe_n ##1 !pins_o.oe_n;
    endproperty
    a_status_reread: assert property (p_status_reread)
        else $error("poll read without fresh output enable edge");

endmodule : fcs_ctrl

/* File: tb/fcs_flash_model.sv */
// Behavioural boot-block flash device driven through its pins
`timescale 1ns/1ns
module fcs_flash_model
    import fcs_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'hC3 // Arbitrary value
) (
    input wire fcs_pins_t pins_i,
    input wire logic rp_n_i,
    input wire logic vpp_en_i,
    input wire logic fail_i,
    input wire logic no_vpp_i,
    output logic [DATA_W-1:0] dq_o
);
    logic [7:0] sr = 8'h80;
    logic [15:0] mem [0:255];
    logic [15:0] out_q = 16'h0000;
    logic [7:0] last = 8'h00;
    logic [7:0] pa;
    logic [15:0] pd;
    logic kind = 1'b1;
    fcs_mode_t md = MD_ARRAY;
    event go_ev;

    initial begin
        for (int i = 0; i < 256; i++) mem[i] = {8'hA5, i[7:0]};
    end

    task automatic start(input logic k, input logic [7:0] a,
                         input logic [15:0] d);
        sr[3] = !vpp_en_i || no_vpp_i;
        if (!sr[3]) begin
            sr[7] = 1'b0;
            kind = k;
            pa = a;
            pd = d;
            -> go_ev;
        end
    endtask : start

    task automatic wr(input logic [17:0] a, input logic [15:0] d);
        logic [7:0] c;
        c = d[7:0];
        if (last == CMD_PROG_SETUP || last == 8'h10) begin
            last = 8'h00;
            md = MD_STATUS;
            if (d != 16'hFFFF && !sr[3]) start(1'b1, a[7:0], d);
        end else if (last == CMD_ERASE_SETUP) begin
            last = 8'h00;
            md = MD_STATUS;
            if (c != CMD_CONFIRM) sr[5:4] = 2'b11;
            else if (!sr[3]) start(1'b0, a[7:0], d);
        end else if (!sr[6] || c == CMD_READ_ARRAY ||
                     c == CMD_READ_STATUS || c == CMD_CONFIRM) begin
            case (c)
                CMD_READ_ARRAY: md = MD_ARRAY;
                CMD_IDENTIFY: md = MD_IDENT;
                CMD_READ_STATUS: md = MD_STATUS;
                CMD_CLEAR_STATUS: sr[5:3] = 3'b000;
                CMD_SUSPEND: begin
                    md = MD_STATUS;
                    if (!sr[7]) sr[7:6] = 2'b11;
                end
                CMD_CONFIRM: begin
                    md = MD_STATUS;
                    if (sr[6]) sr[7:6] = 2'b00;
                end
                default: last = c;
            endcase
        end
    endtask : wr

    always @(posedge pins_i.we_n or negedge rp_n_i) begin
        if (!rp_n_i) begin
            sr = 8'h80;
            md = MD_ARRAY;
            last = 8'h00;
        // Busy erase takes only the suspend command
        end else if (!pins_i.ce_n && pins_i.dq_oe && (sr[7] ||
                     (!kind && pins_i.dq_o[7:0] == CMD_SUSPEND))) begin
            wr(pins_i.addr, pins_i.dq_o);
        end
    end

    always @(go_ev) begin
        #1500;
        wait (!sr[6]);
        // Reset during the operation abandons it
        if (rp_n_i && !sr[7]) begin
            if (fail_i) sr[kind ? 4 : 5] = 1'b1;
            else if (kind) mem[pa] = mem[pa] & pd;
            else for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
            sr[7] = 1'b1;
        end
    end

    // Output latched on the output-enable fall only
    always @(negedge pins_i.oe_n) begin
        if (!pins_i.ce_n) begin
            if (md == MD_STATUS || !sr[7]) out_q = {8'h00, sr & 8'hF8};
            else if (md == MD_IDENT)
                out_q = {8'h00, pins_i.addr[0] ? PART_CODE : MAKER_CODE};
            else out_q = mem[pins_i.addr[7:0]];
        end
    end

    // Released bus shows the inverse of the last value
    assign dq_o = (!pins_i.ce_n && !pins_i.oe_n) ? out_q : ~out_q;
endmodule : fcs_flash_model

/* File: tb/fcs_ctrl_test.sv */
// Self-checking bench for the flash command and status controller
`timescale 1ns/1ns
module fcs_ctrl_test;
    import fcs_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic fail = 1'b0;
    logic no_vpp = 1'b0;
    fcs_req_t req_i = '0;
    wire fcs_pins_t pins;
    logic [DATA_W-1:0] dq, rdata_o;
    logic [7:0] status_o;
    logic req_ready_o, done_o, error_o, rp_n, vpp_en;
    logic byte_n, wp, unlock = 1'b0, wp_seen = 1'b0;
    int errors = 0;
    int n_checks = 0;

    fcs_ctrl uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .dq_i(dq),
        .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o),
        .status_o(status_o), .error_o(error_o), .pins_o(pins),
        .rp_n_o(rp_n), .byte_n_o(byte_n), .vpp_en_o(vpp_en), .wp_o(wp));
    fcs_flash_model dev (.pins_i(pins), .rp_n_i(rp_n), .vpp_en_i(vpp_en),
        .fail_i(fail), .no_vpp_i(no_vpp), .dq_o(dq));

    initial forever #25 core_clk_i = ~core_clk_i;

    // Unlock level seen while the supply is on
    always @(negedge core_clk_i) if (vpp_en) wp_seen <= wp;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results

    task automatic run(input fcs_op_t op, input logic [17:0] a,
                       input logic [15:0] d);
        int i;
        @(negedge core_clk_i);
        req_valid_i = 1'b1;
        req_i = '{op, a, d, unlock};
        i = 0;
        while (req_ready_o !== 1'b1 && i < 100) begin
            @(negedge core_clk_i);
            i++;
        end
        if (i == 100) errors++;
        @(negedge core_clk_i);
        req_valid_i = 1'b0;
        i = 0;
        while (done_o !== 1'b1 && i < 5000) begin
            @(negedge core_clk_i);
            i++;
        end
        if (i == 5000) errors++;
    endtask : run

    task automatic reset_dut;
        rst_n_i = 1'b0;
        repeat (12) @(negedge core_clk_i);
        check({15'h0000, rp_n}, 16'h0000);
        rst_n_i = 1'b1;
    endtask : reset_dut

    initial begin
        reset_dut();
        run(OP_STATUS, 18'h00000, 16'h0000);
        check({8'h00, status_o}, 16'h0080);
        check({15'h0000, byte_n}, 16'h0001);
        run(OP_READ, 18'h00005, 16'h0000);
        check(rdata_o, 16'hA505);
        for (int i = 0; i < 2; i++) begin
            run(OP_IDENT, 18'(i), 16'h0000);
            check(rdata_o, i ? 16'h00C3 : 16'h005A);
        end
        run(OP_PROGRAM, 18'h00005, 16'h0F0F);
        check({8'h00, status_o}, 16'h0080);
        check({15'h0000, wp_seen}, 16'h0000);
        run(OP_READ, 18'h00005, 16'h0000);
        check(rdata_o, 16'h0505);
        fail = 1'b1;
        run(OP_PROGRAM, 18'h00006, 16'h0000);
        check({8'h00, status_o}, 16'h0090);
        check({15'h0000, error_o}, 16'h0001);
        run(OP_ERASE, 18'h00000, 16'h0000);
        check({8'h00, status_o}, 16'h00B0);
        run(OP_CLEAR, 18'h00000, 16'h0000);
        run(OP_STATUS, 18'h00000, 16'h0000);
        check({8'h00, status_o}, 16'h0080);
        check({15'h0000, error_o}, 16'h0000);
        fail = 1'b0;
        run(OP_ERASE, 18'h3F000, 16'h0000);
        run(OP_READ, 18'h00005, 16'h0000);
        check(rdata_o, 16'hFFFF);
        no_vpp = 1'b1;
        run(OP_PROGRAM, 18'h00007, 16'h0000);
        check({8'h00, status_o}, 16'h0088);
        no_vpp = 1'b0;
        run(OP_PROGRAM, 18'h00007, 16'h0000);
        check({8'h00, status_o}, 16'h0088);
        run(OP_READ, 18'h00007, 16'h0000);
        check(rdata_o, 16'hFFFF);
        run(OP_CLEAR, 18'h00000, 16'h0000);
        unlock = 1'b1;
        run(OP_PROGRAM, 18'h00007, 16'h1234);
        unlock = 1'b0;
        check({15'h0000, wp_seen}, 16'h0001);
        check({15'h0000, vpp_en}, 16'h0000);
        run(OP_READ, 18'h00007, 16'h0000);
        check(rdata_o, 16'h1234);
        run(OP_SUSPEND, 18'h00000, 16'h0000);
        check({8'h00, status_o}, 16'h0080);
        run(OP_RESUME, 18'h00000, 16'h0000);
        check({8'h00, status_o}, 16'h0080);
        fail = 1'b1;
        run(OP_PROGRAM, 18'h00008, 16'h0000);
        fail = 1'b0;
        reset_dut();
        run(OP_STATUS, 18'h00000, 16'h0000);
        check({8'h00, status_o}, 16'h0080);
        results();
    end

    initial begin
        #2000000;
        errors++;
        results();
    end
endmodule : fcs_ctrl_test
